// ---- hw/fcra_top.sv ----
// Configuration register bank with parallel and serial access paths.
`timescale 1ns/1ps
module fcra_top (
  // Core clock and master reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Parallel ports, sampled pins
  input wire logic wclk_i,
  input wire logic rclk_i,
  input wire logic wen_n_i,
  input wire logic ren_n_i,
  input wire logic config_port_select_i,
  input wire logic config_load_n_i,
  input wire logic [fcra_pkg::REG_W-1:0] wdata_i,
  output logic [fcra_pkg::REG_W-1:0] rdata_o,
  // Serial link
  input wire logic cfg_sclk_i,
  input wire logic serial_in_i,
  // Queue memory side
  output logic fifo_wr_o,
  output logic [fcra_pkg::REG_W-1:0] fifo_wdata_o,
  output logic fifo_rd_o,
  input wire logic [fcra_pkg::REG_W-1:0] fifo_rdata_i,
  // Settings in force
  output logic [fcra_pkg::QUEUE_W-1:0] cfg_queues_o,
  output logic cfg_fast_clk_o,
  output logic cfg_settling_o
);

  // ---------------------------------------------------------------
  // Serial receiver on the link clock
  // ---------------------------------------------------------------
  fcra_ser_if ser ();

  fcra_serial_rx u_serial (
    .sclk_i(cfg_sclk_i),
    .rstn_i(rstn_i),
    .config_port_select_i(config_port_select_i),
    .config_load_n_i(config_load_n_i),
    .serial_in_i(serial_in_i),
    .ser(ser.src)
  );

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Pins and data go through the same three stages so they stay aligned
  logic [fcra_pkg::SYNC_W-1:0] raw;
  logic [fcra_pkg::SYNC_W-1:0] s1_reg, s2_reg, s3_reg;
  logic [fcra_pkg::SYNC_W-1:0] filt_reg, filt_next;

  assign raw = {wdata_i, ser.tgl, config_port_select_i, config_load_n_i, ren_n_i, wen_n_i, rclk_i, wclk_i};

  // A change counts only once stages two and three agree
  for (genvar i = 0; i < fcra_pkg::SYNC_W; i++) begin : g_sync
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        s1_reg[i] <= 1'b0;
        s2_reg[i] <= 1'b0;
        s3_reg[i] <= 1'b0;
      end else begin
        s1_reg[i] <= raw[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
      end
    end
    assign filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : filt_reg[i];
  end

  // ---------------------------------------------------------------
  // Decoded accesses
  // ---------------------------------------------------------------
  logic wclk_rise, rclk_rise, ser_ev;
  logic wen_s, ren_s, load_s, psel_s;
  logic [fcra_pkg::REG_W-1:0] wdata_s;
  logic wr_cfg, rd_cfg, fifo_wr, fifo_rd, idle_cfg;
  logic [fcra_pkg::PTR_W-1:0] ser_idx;

  assign wclk_rise = filt_next[fcra_pkg::S_WCLK] & ~filt_reg[fcra_pkg::S_WCLK];
  assign rclk_rise = filt_next[fcra_pkg::S_RCLK] & ~filt_reg[fcra_pkg::S_RCLK];
  assign ser_ev = filt_next[fcra_pkg::S_TGL] ^ filt_reg[fcra_pkg::S_TGL];
  assign wen_s = filt_next[fcra_pkg::S_WEN];
  assign ren_s = filt_next[fcra_pkg::S_REN];
  assign load_s = filt_next[fcra_pkg::S_LOAD];
  assign psel_s = filt_next[fcra_pkg::S_PSEL];
  assign wdata_s = filt_next[fcra_pkg::SYNC_W-1:fcra_pkg::S_DATA];

  // Register path needs select high; select low with load low is left idle
  assign wr_cfg = wclk_rise & psel_s & ~load_s & ~wen_s & ren_s;
  assign rd_cfg = rclk_rise & psel_s & ~load_s & ~ren_s & wen_s;
  assign idle_cfg = psel_s & ~load_s & wen_s & ren_s;
  assign fifo_wr = wclk_rise & load_s & ~wen_s;
  assign fifo_rd = rclk_rise & load_s & ~ren_s;

  // Serial address one maps to bank index zero
  assign ser_idx = fcra_pkg::PTR_W'(ser.addr - fcra_pkg::ADDR_FIRST);

  // ---------------------------------------------------------------
  // Register bank and pointers
  // ---------------------------------------------------------------
  logic [fcra_pkg::NUM_REGS-1:0][fcra_pkg::REG_W-1:0] cfg_reg, cfg_next;
  logic [fcra_pkg::PTR_W-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [fcra_pkg::REG_W-1:0] rdata_reg, rdata_next, fwdata_reg, fwdata_next;
  logic fwr_reg, frd_reg;
  logic [fcra_pkg::REG_W-1:0] rd_sel_val;

  assign rd_sel_val = cfg_reg[rptr_reg];

  // Parallel write wins a collision; the host never overlaps the two paths
  always_comb begin
    cfg_next = cfg_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    rdata_next = rdata_reg;
    fwdata_next = fwdata_reg;
    if (wr_cfg) begin
      cfg_next[wptr_reg] = wdata_s;
      wptr_next = (wptr_reg == fcra_pkg::PTR_LAST) ? fcra_pkg::PTR_FIRST : wptr_reg + fcra_pkg::PTR_STEP;
    end else if (ser_ev) begin
      cfg_next[ser_idx] = ser.data;
    end
    if (rd_cfg) begin
      rdata_next = rd_sel_val;
      rptr_next = (rptr_reg == fcra_pkg::PTR_LAST) ? fcra_pkg::PTR_FIRST : rptr_reg + fcra_pkg::PTR_STEP;
    end else if (fifo_rd) begin
      rdata_next = fifo_rdata_i;
    end
    if (fifo_wr) begin
      fwdata_next = wdata_s;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filt_reg <= '0;
      cfg_reg <= fcra_pkg::CFG_DEFAULT;
      wptr_reg <= fcra_pkg::PTR_FIRST;
      rptr_reg <= fcra_pkg::PTR_FIRST;
      rdata_reg <= '0;
      fwdata_reg <= '0;
      fwr_reg <= 1'b0;
      frd_reg <= 1'b0;
    end else begin
      filt_reg <= filt_next;
      cfg_reg <= cfg_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      rdata_reg <= rdata_next;
      fwdata_reg <= fwdata_next;
      fwr_reg <= fifo_wr;
      frd_reg <= fifo_rd;
    end
  end

  // ---------------------------------------------------------------
  // Settling delay before new settings apply
  // ---------------------------------------------------------------
  // Each new write restarts the count, so bursts apply once at the end
  logic any_wr;
  logic pend_reg, pend_next;
  logic [fcra_pkg::SETTLE_W-1:0] scnt_reg, scnt_next;
  logic [fcra_pkg::QUEUE_W-1:0] actq_reg, actq_next;
  logic actf_reg, actf_next;

  assign any_wr = wr_cfg | ser_ev;

  always_comb begin
    pend_next = pend_reg;
    scnt_next = scnt_reg;
    actq_next = actq_reg;
    actf_next = actf_reg;
    if (any_wr) begin
      pend_next = 1'b1;
      scnt_next = fcra_pkg::SETTLE_ZERO;
    end else if (pend_reg && wclk_rise) begin
      if (scnt_reg == fcra_pkg::SETTLE_LAST) begin
        pend_next = 1'b0;
        actq_next = cfg_reg[fcra_pkg::QUEUE_IDX][fcra_pkg::QUEUE_W-1:0];
        actf_next = cfg_reg[fcra_pkg::FAST_IDX][fcra_pkg::FAST_BIT];
      end else begin
        scnt_next = scnt_reg + fcra_pkg::SETTLE_STEP;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_reg <= 1'b0;
      scnt_reg <= fcra_pkg::SETTLE_ZERO;
      actq_reg <= fcra_pkg::CFG_DEFAULT[fcra_pkg::QUEUE_IDX][fcra_pkg::QUEUE_W-1:0];
      actf_reg <= fcra_pkg::CFG_DEFAULT[fcra_pkg::FAST_IDX][fcra_pkg::FAST_BIT];
    end else begin
      pend_reg <= pend_next;
      scnt_reg <= scnt_next;
      actq_reg <= actq_next;
      actf_reg <= actf_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata_o = rdata_reg;
  assign fifo_wr_o = fwr_reg;
  assign fifo_rd_o = frd_reg;
  assign fifo_wdata_o = fwdata_reg;
  assign cfg_queues_o = actq_reg;
  assign cfg_fast_clk_o = actf_reg;
  assign cfg_settling_o = pend_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_last_edge;
    pend_reg && wclk_rise && !any_wr && scnt_reg == fcra_pkg::SETTLE_LAST;
  endsequence

  a_wr_store: assert property (wr_cfg |=> cfg_reg[$past(wptr_reg)] == $past(wdata_s))
    else $error("parallel write not stored");

  a_wr_step: assert property (wr_cfg && wptr_reg != fcra_pkg::PTR_LAST
    |=> wptr_reg == $past(wptr_reg) + fcra_pkg::PTR_STEP)
    else $error("write pointer did not advance");

  a_wr_wrap: assert property (wr_cfg && wptr_reg == fcra_pkg::PTR_LAST |=> wptr_reg == fcra_pkg::PTR_FIRST)
    else $error("write pointer did not wrap");

  a_rd_data: assert property (rd_cfg |=> rdata_o == $past(rd_sel_val))
    else $error("parallel read returned wrong register");

  a_rd_wrap: assert property (rd_cfg && rptr_reg == fcra_pkg::PTR_LAST |=> rptr_reg == fcra_pkg::PTR_FIRST)
    else $error("read pointer did not wrap");

  a_idle_none: assert property (idle_cfg && !ser_ev |=> $stable(cfg_reg) && !fifo_wr_o && !fifo_rd_o)
    else $error("access during idle combination");

  a_fifo_wr: assert property (fifo_wr |=> fifo_wr_o && fifo_wdata_o == $past(wdata_s) && $stable(wptr_reg))
    else $error("queue write not forwarded");

  a_fifo_rd: assert property (fifo_rd |=> fifo_rd_o && rdata_o == $past(fifo_rdata_i) && $stable(rptr_reg))
    else $error("queue read not forwarded");

  a_settle_apply: assert property (s_last_edge |=> !pend_reg
    && cfg_queues_o == $past(cfg_reg[fcra_pkg::QUEUE_IDX][fcra_pkg::QUEUE_W-1:0])
    && cfg_fast_clk_o == $past(cfg_reg[fcra_pkg::FAST_IDX][fcra_pkg::FAST_BIT]))
    else $error("settings not applied after eight edges");

  a_settle_early: assert property ($changed(cfg_queues_o)
    |-> $past(pend_reg) && $past(scnt_reg) == fcra_pkg::SETTLE_LAST)
    else $error("settings applied early");

  // ---------------------------------------------------------------
  // Checks on read pointer, serial handover and settling hold
  // ---------------------------------------------------------------
  // A serial write with no parallel register write or read in the same cycle
  sequence s_ser_taken;
    ser_ev && !wr_cfg && !rd_cfg;
  endsequence

  // A pending change that this cycle neither restarts nor completes
  sequence s_settle_wait;
    pend_reg && !any_wr && !(wclk_rise && scnt_reg == fcra_pkg::SETTLE_LAST);
  endsequence

  a_rd_step: assert property (rd_cfg && rptr_reg != fcra_pkg::PTR_LAST
    |=> rptr_reg == $past(rptr_reg) + fcra_pkg::PTR_STEP)
    else $error("read pointer did not advance");

  // Serial address n must land in bank slot n minus one
  a_ser_write: assert property (s_ser_taken |=> cfg_reg[$past(ser_idx)] == $past(ser.data))
    else $error("serial write not stored");

  // The serial path owns no pointer, so parallel sequencing is undisturbed
  a_ser_ptrs: assert property (s_ser_taken |=> $stable(wptr_reg) && $stable(rptr_reg))
    else $error("serial write moved a parallel pointer");

  // Only a parallel register read or a queue read changes the read port, never a serial frame
  a_rd_hold: assert property (!rd_cfg && !fifo_rd |=> $stable(rdata_o))
    else $error("read port changed without a read");

  a_settle_start: assert property (any_wr |=> cfg_settling_o && scnt_reg == fcra_pkg::SETTLE_ZERO)
    else $error("write did not restart the settling count");

  // Settings in force stay put for the whole wait
  a_settle_hold: assert property (s_settle_wait |=> cfg_settling_o
    && $stable(cfg_queues_o) && $stable(cfg_fast_clk_o))
    else $error("settings changed while still settling");

endmodule // fcra_top

// ---- hw/fcra_pkg.sv ----
// Constants shared by the configuration register access block.
package fcra_pkg;

  // ---------------------------------------------------------------
  // Register bank shape
  // ---------------------------------------------------------------
  localparam int NUM_REGS = 10;
  localparam int REG_W = 8;
  localparam int PTR_W = 4;
  localparam logic [PTR_W-1:0] PTR_FIRST = 4'h0;
  localparam logic [PTR_W-1:0] PTR_LAST = 4'h9;
  localparam logic [PTR_W-1:0] PTR_STEP = 4'h1;

  // Fields that steer the rest of the device
  localparam logic [PTR_W-1:0] QUEUE_IDX = 4'h2;
  localparam int QUEUE_W = 3;
  localparam logic [PTR_W-1:0] FAST_IDX = 4'h9;
  localparam int FAST_BIT = 7;

  // Values after master reset, register ten first, register one last
  localparam logic [NUM_REGS-1:0][REG_W-1:0] CFG_DEFAULT = {
    8'h80, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h7f, 8'h07, 8'h00, 8'h00};

  // ---------------------------------------------------------------
  // Serial frame
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int BITCNT_W = 5;
  localparam logic [BITCNT_W-1:0] BIT_FIRST = 5'h00;
  localparam logic [BITCNT_W-1:0] BIT_LAST = 5'h17;
  localparam logic [BITCNT_W-1:0] BIT_STEP = 5'h01;
  localparam int INSTR_MSB = 23;
  localparam int INSTR_LSB = 16;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam logic [REG_W-1:0] WR_INSTR = 8'h02;
  localparam logic [REG_W-1:0] ADDR_FIRST = 8'h01;
  localparam logic [REG_W-1:0] ADDR_LAST = 8'h0a;

  // ---------------------------------------------------------------
  // Settling delay in write-clock edges
  // ---------------------------------------------------------------
  localparam int SETTLE_W = 4;
  localparam logic [SETTLE_W-1:0] SETTLE_EDGES = 4'h8;
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 4'h0;
  localparam logic [SETTLE_W-1:0] SETTLE_STEP = 4'h1;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_EDGES - SETTLE_STEP;

  // ---------------------------------------------------------------
  // Input synchroniser bank layout
  // ---------------------------------------------------------------
  localparam int S_WCLK = 0;
  localparam int S_RCLK = 1;
  localparam int S_WEN = 2;
  localparam int S_REN = 3;
  localparam int S_LOAD = 4;
  localparam int S_PSEL = 5;
  localparam int S_TGL = 6;
  localparam int S_DATA = 7;
  localparam int SYNC_W = 15;

endpackage

// ---- hw/fcra_ser_if.sv ----
// Carrier from the serial receiver to the core register bank.
`timescale 1ns/1ps
interface fcra_ser_if;
  logic tgl;
  logic [fcra_pkg::REG_W-1:0] addr;
  logic [fcra_pkg::REG_W-1:0] data;
  modport src (output tgl, output addr, output data);
  modport dst (input tgl, input addr, input data);
endinterface

// ---- hw/fcra_serial_rx.sv ----
// Serial configuration receiver running on the serial clock.
`timescale 1ns/1ps
module fcra_serial_rx (
  // Serial link
  input wire logic sclk_i,
  input wire logic rstn_i,
  input wire logic config_port_select_i,
  input wire logic config_load_n_i,
  input wire logic serial_in_i,
  // Toward the core
  fcra_ser_if.src ser
);

  // ---------------------------------------------------------------
  // Frame state, cleared whenever the link is deselected
  // ---------------------------------------------------------------
  // No edge comes between frames, so deselect itself clears the count
  logic frst_n;
  logic [fcra_pkg::FRAME_BITS-1:0] shift_reg, shift_next;
  logic [fcra_pkg::BITCNT_W-1:0] cnt_reg, cnt_next;
  logic [fcra_pkg::FRAME_BITS-1:0] word;
  logic word_ok;
  localparam int ADDR_MSB_M1 = fcra_pkg::ADDR_MSB - 1; // Address sits one place lower before the last shift

  assign frst_n = rstn_i & ~config_port_select_i;

  // Shift one bit per edge, first bit is the most significant
  always_comb begin
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    word = {shift_reg[fcra_pkg::FRAME_BITS-2:0], serial_in_i};
    if (config_load_n_i) begin
      shift_next = word;
      cnt_next = (cnt_reg == fcra_pkg::BIT_LAST) ? fcra_pkg::BIT_FIRST : cnt_reg + fcra_pkg::BIT_STEP;
    end
  end

  always_ff @(posedge sclk_i or negedge frst_n) begin
    if (!frst_n) begin
      shift_reg <= '0;
      cnt_reg <= fcra_pkg::BIT_FIRST;
    end else begin
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // Completed write, handed over by toggle
  // ---------------------------------------------------------------
  // Hold registers survive deselect so the core can still read them
  logic tgl_reg, tgl_next;
  logic [fcra_pkg::REG_W-1:0] addr_reg, addr_next, data_reg, data_next;

  assign word_ok = config_load_n_i && cnt_reg == fcra_pkg::BIT_LAST
    && word[fcra_pkg::INSTR_MSB:fcra_pkg::INSTR_LSB] == fcra_pkg::WR_INSTR
    && word[fcra_pkg::ADDR_MSB:fcra_pkg::ADDR_LSB] >= fcra_pkg::ADDR_FIRST
    && word[fcra_pkg::ADDR_MSB:fcra_pkg::ADDR_LSB] <= fcra_pkg::ADDR_LAST;

  // Only a write instruction to a mapped address is passed on
  always_comb begin
    tgl_next = tgl_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    if (word_ok && frst_n) begin
      tgl_next = ~tgl_reg;
      addr_next = word[fcra_pkg::ADDR_MSB:fcra_pkg::ADDR_LSB];
      data_next = word[fcra_pkg::DATA_MSB:0];
    end
  end

  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgl_reg <= 1'b0;
      addr_reg <= '0;
      data_reg <= '0;
    end else begin
      tgl_reg <= tgl_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end

  assign ser.tgl = tgl_reg;
  assign ser.addr = addr_reg;
  assign ser.data = data_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_good_frame;
    word_ok;
  endsequence

  a_ser_shift: assert property (@(posedge sclk_i) disable iff (!frst_n)
    config_load_n_i |=> shift_reg[0] == $past(serial_in_i))
    else $error("serial bit not shifted in");

  a_ser_store: assert property (@(posedge sclk_i) disable iff (!frst_n)
    s_good_frame |=> tgl_reg != $past(tgl_reg)
      && data_reg == $past({shift_reg[fcra_pkg::DATA_MSB-1:0], serial_in_i})
      && addr_reg == $past(shift_reg[ADDR_MSB_M1:fcra_pkg::DATA_MSB]))
    else $error("serial write not handed over");

  a_ser_instr: assert property (@(posedge sclk_i) disable iff (!frst_n)
    (cnt_reg == fcra_pkg::BIT_LAST && word[fcra_pkg::INSTR_MSB:fcra_pkg::INSTR_LSB] != fcra_pkg::WR_INSTR)
      |=> $stable(tgl_reg))
    else $error("write taken without write instruction");

endmodule // fcra_serial_rx

// ---- bench/fcra_host_model.sv ----
// Host controller model driving the parallel pins and the serial link.
`timescale 1ns/1ps
module fcra_host_model (
  // Core clock reference
  input wire logic clk_i,
  // Parallel pins
  output logic wclk_o,
  output logic rclk_o,
  output logic wen_n_o,
  output logic ren_n_o,
  output logic sel_o,
  output logic load_n_o,
  output logic [fcra_pkg::REG_W-1:0] wdata_o,
  // Serial link
  output logic sclk_o,
  output logic sdata_o
);
  // ------------------------------------------------------------
  // Pin levels and mode changes
  // ------------------------------------------------------------
  // Parallel mode with both enables off, so nothing happens at start
  initial begin
    {wclk_o, rclk_o, sclk_o, sdata_o} = 4'h0;
    {wen_n_o, ren_n_o, sel_o, load_n_o} = 4'he;
    wdata_o = 8'h00;
  end

  // Load and select move in an order that never passes select low with load low
  task automatic set_mode(input logic sel, input logic load_n, input logic wen_n, input logic ren_n);
    @(posedge clk_i);
    wen_n_o <= wen_n;
    ren_n_o <= ren_n;
    if (load_n) begin
      load_n_o <= 1'b1;
      @(posedge clk_i);
      sel_o <= sel;
    end else begin
      sel_o <= sel;
      @(posedge clk_i);
      load_n_o <= 1'b0;
    end
  endtask

  // ------------------------------------------------------------
  // Transfers
  // ------------------------------------------------------------
  // Each phase lasts four core cycles, longer than the sampler needs
  task automatic pulse(input logic do_w, input logic do_r);
    @(posedge clk_i);
    wclk_o <= do_w;
    rclk_o <= do_r;
    repeat (4) @(posedge clk_i);
    wclk_o <= 1'b0;
    rclk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // Word leads the clock by a cycle, then shows its inverse once released
  task automatic par_write(input logic [fcra_pkg::REG_W-1:0] word);
    @(posedge clk_i);
    wdata_o <= word;
    pulse(1'b1, 1'b0);
    wdata_o <= ~word;
  endtask

  // Link clock runs only inside the frame; bits change on its falling edge
  task automatic frame(input logic [fcra_pkg::FRAME_BITS-1:0] bits);
    int i;
    @(posedge clk_i);
    #3;
    for (i = fcra_pkg::FRAME_BITS - 1; i >= 0; i--) begin
      sdata_o <= bits[i];
      #6 sclk_o <= 1'b1;
      #6 sclk_o <= 1'b0;
    end
    sdata_o <= ~bits[0];
    repeat (12) @(posedge clk_i);
    #1;
  endtask
endmodule // fcra_host_model

// ---- bench/fcra_top_tb.sv ----
// Self-checking bench for the configuration register access block.
`timescale 1ns/1ps
module fcra_top_tb;
  // Pins, queue memory side and bookkeeping
  logic clk_i, rstn_i, wclk, rclk, wen_n, ren_n, sel, load_n, sclk, sdata;
  logic fifo_wr, fifo_rd, fast, settling;
  logic [7:0] wdata, rdata, fifo_wdata, fifo_rdata;
  logic [2:0] queues;
  int fails, check_count, wr_cnt, rd_cnt;

  // ------------------------------------------------------------
  // Clock, design and host
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  fcra_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .wclk_i(wclk), .rclk_i(rclk), .wen_n_i(wen_n),
    .ren_n_i(ren_n), .config_port_select_i(sel), .config_load_n_i(load_n), .wdata_i(wdata),
    .rdata_o(rdata), .cfg_sclk_i(sclk), .serial_in_i(sdata), .fifo_wr_o(fifo_wr),
    .fifo_wdata_o(fifo_wdata), .fifo_rd_o(fifo_rd), .fifo_rdata_i(fifo_rdata),
    .cfg_queues_o(queues), .cfg_fast_clk_o(fast), .cfg_settling_o(settling));

  fcra_host_model host (.clk_i(clk_i), .wclk_o(wclk), .rclk_o(rclk), .wen_n_o(wen_n),
    .ren_n_o(ren_n), .sel_o(sel), .load_n_o(load_n), .wdata_o(wdata), .sclk_o(sclk), .sdata_o(sdata));

  // Queue memory strobes counted; a one-cycle pulse counts once
  always @(posedge clk_i) begin
    if (fifo_wr === 1'b1) wr_cnt++;
    if (fifo_rd === 1'b1) rd_cnt++;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Counters cleared while reset holds the strobes low
  task automatic do_reset();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wr_cnt = 0;
    rd_cnt = 0;
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Defaults after reset, then eleven reads so the last one wraps
  task automatic test_defaults();
    int n;
    do_reset();
    check8({5'h00, queues}, {5'h00, fcra_pkg::CFG_DEFAULT[2][2:0]});
    check1(fast, fcra_pkg::CFG_DEFAULT[9][7]);
    check1(settling, 1'b0);
    host.set_mode(1'b1, 1'b0, 1'b1, 1'b0);
    for (n = 0; n < 11; n++) begin
      host.pulse(1'b0, 1'b1);
      check8(rdata, fcra_pkg::CFG_DEFAULT[n % 10]);
    end
    host.set_mode(1'b1, 1'b0, 1'b1, 1'b1);
  endtask

  // Eleven writes wrap onto register one; settings wait eight write edges
  task automatic test_par_write();
    int n;
    do_reset();
    host.set_mode(1'b1, 1'b0, 1'b0, 1'b1);
    for (n = 0; n < 11; n++) host.par_write(8'h10 + 8'(n));
    host.set_mode(1'b1, 1'b0, 1'b1, 1'b1);
    check1(settling, 1'b1);
    for (n = 0; n < 7; n++) host.pulse(1'b1, 1'b1);
    check8({5'h00, queues}, 8'h07);
    check1(settling, 1'b1);
    host.pulse(1'b1, 1'b1);
    check8({5'h00, queues}, 8'h02);
    check1(fast, 1'b0);
    check1(settling, 1'b0);
    check8(8'(wr_cnt + rd_cnt), 8'h00);
    host.set_mode(1'b1, 1'b0, 1'b1, 1'b0);
    for (n = 0; n < 10; n++) begin
      host.pulse(1'b0, 1'b1);
      check8(rdata, (n == 0) ? 8'h1a : 8'h10 + 8'(n));
    end
    host.set_mode(1'b1, 1'b0, 1'b1, 1'b1);
  endtask

  // Queue memory traffic under both select levels leaves the bank alone
  task automatic test_fifo();
    int k;
    do_reset();
    for (k = 0; k < 2; k++) begin
      host.set_mode(k[0], 1'b1, 1'b0, 1'b1);
      host.par_write(8'hc0 + 8'(k));
      check8(fifo_wdata, 8'hc0 + 8'(k));
      check8(8'(wr_cnt), 8'(k + 1));
      @(posedge clk_i);
      fifo_rdata <= 8'h5a + 8'(k);
      host.set_mode(k[0], 1'b1, 1'b1, 1'b0);
      host.pulse(1'b0, 1'b1);
      check8(rdata, 8'h5a + 8'(k));
      check8(8'(rd_cnt), 8'(k + 1));
    end
    check1(settling, 1'b0);
    host.set_mode(1'b1, 1'b0, 1'b1, 1'b1);
  endtask

  // Serial writes to every register, three refused frames, read back in parallel
  task automatic test_serial();
    int n;
    do_reset();
    host.set_mode(1'b0, 1'b1, 1'b1, 1'b1);
    for (n = 1; n <= 10; n++) host.frame({fcra_pkg::WR_INSTR, 8'(n), 8'h20 + 8'(n)});
    host.frame({8'h03, 8'h01, 8'hee});
    host.frame({fcra_pkg::WR_INSTR, 8'h0b, 8'hee});
    host.frame({fcra_pkg::WR_INSTR, 8'h00, 8'hee});
    for (n = 0; n < 8; n++) host.pulse(1'b1, 1'b0);
    check8({5'h00, queues}, 8'h03);
    check1(fast, 1'b0);
    host.set_mode(1'b1, 1'b0, 1'b1, 1'b0);
    for (n = 1; n <= 10; n++) begin
      host.pulse(1'b0, 1'b1);
      check8(rdata, 8'h20 + 8'(n));
    end
    host.set_mode(1'b1, 1'b0, 1'b1, 1'b1);
  endtask

  // Main sequence; each scenario starts from its own reset
  initial begin
    rstn_i = 1'b0;
    fifo_rdata = 8'h00;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    test_defaults();
    test_par_write();
    test_fifo();
    test_serial();
    stop_test();
  end

  // Watchdog, several times the expected run length
  initial begin
    #50000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule // fcra_top_tb
